// >>> hdl/dpc_pkg.sv
// Package of constants and register map for the disk position and count capture block
package dpc_pkg;
  localparam int CW      = 16;
  localparam int IDW     = 64;
  localparam int AW      = 8;
  localparam int NIRQ    = 3;

  localparam logic [AW-1:0] OFF_CTRL      = 8'h00;
  localparam logic [AW-1:0] OFF_EXP_ID    = 8'h04;
  localparam logic [AW-1:0] OFF_ACTA_LO   = 8'h08;
  localparam logic [AW-1:0] OFF_ACTA_HI   = 8'h0C;
  localparam logic [AW-1:0] OFF_ACTB_LO   = 8'h10;
  localparam logic [AW-1:0] OFF_ACTB_HI   = 8'h14;
  localparam logic [AW-1:0] OFF_CAP_LO    = 8'h18;
  localparam logic [AW-1:0] OFF_CAP_HI    = 8'h1C;
  localparam logic [AW-1:0] OFF_DSTAT     = 8'h20;
  localparam logic [AW-1:0] OFF_INT_CNT   = 8'h24;
  localparam logic [AW-1:0] OFF_EXT_CNT   = 8'h28;
  localparam logic [AW-1:0] OFF_GOOD_CNT  = 8'h2C;
  localparam logic [AW-1:0] OFF_SNAP_EXT  = 8'h30;
  localparam logic [AW-1:0] OFF_SNAP_GOOD = 8'h34;
  localparam logic [AW-1:0] OFF_PIPE_CNT  = 8'h38;
  localparam logic [AW-1:0] OFF_IRQ_STAT  = 8'h3C;
  localparam logic [AW-1:0] OFF_IRQ_MASK  = 8'h40;

  // Control register bits
  localparam int CTRL_LBA     = 0;
  localparam int CTRL_LBA4    = 1;
  localparam int CTRL_SKIP    = 2;
  localparam int CTRL_WRITE   = 3;
  localparam int CTRL_REARM   = 4;
  localparam int CTRL_RELEASE = 5;
  localparam int CTRL_SNAP    = 6;
  localparam int CTRL_W       = 4;

  // Disk status bits
  localparam int DST_SEL_B = 0;
  localparam int DST_FULL  = 1;
  localparam int DST_PEND  = 2;
  localparam int DST_STOP  = 3;
  localparam int DST_UPD   = 4;

  // Interrupt status bits
  localparam int IRQ_CAP    = 0;
  localparam int IRQ_UNCORR = 1;
  localparam int IRQ_PEND   = 2;

  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
  localparam logic [31:0]       EXP_RST  = 32'h0000_0000;
  localparam logic [NIRQ-1:0]   MASK_RST = 3'h0;
endpackage

// >>> hdl/dpc_if.sv
// Interfaces between the top module and its counter and ID register modules
interface dpc_cnt_if;
  import dpc_pkg::*;
  logic          ld;
  logic [CW-1:0] ld_val;
  logic          inc;
  logic          dec;
  logic [CW-1:0] q;
  modport ctl (output ld, ld_val, inc, dec, input q);
  modport cnt (input ld, ld_val, inc, dec, output q);
endinterface

interface dpc_id_if;
  import dpc_pkg::*;
  logic           ld;
  logic [IDW-1:0] d;
  logic [IDW-1:0] q;
  modport ctl (output ld, d, input q);
  modport reg_side (input ld, d, output q);
endinterface

// >>> hdl/dpc_cnt.sv
// Loadable up/down block counter
module dpc_cnt (
  input  wire logic i_clk,
  input  wire logic i_rst,
  dpc_cnt_if.cnt    c
);
  import dpc_pkg::*;
  typedef struct packed {
    logic [CW-1:0] q;
  } dpc_cnt_st_t;
  dpc_cnt_st_t s_r;
  dpc_cnt_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    // Load wins so a pipeline reload is never lost to a block step
    if (c.ld) begin
      s_nxt.q = c.ld_val;
    end else if (c.inc && !c.dec) begin
      s_nxt.q = s_r.q + 1'b1;
    end else if (c.dec && !c.inc) begin
      s_nxt.q = s_r.q - 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign c.q = s_r.q;
endmodule

// >>> hdl/dpc_idset.sv
// Eight-byte ID register set
module dpc_idset (
  input  wire logic i_clk,
  input  wire logic i_rst,
  dpc_id_if.reg_side r
);
  import dpc_pkg::*;
  typedef struct packed {
    logic [IDW-1:0] q;
  } dpc_id_st_t;
  dpc_id_st_t s_r;
  dpc_id_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (r.ld) begin
      s_nxt.q = r.d;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign r.q = s_r.q;
endmodule

// >>> hdl/dpc_top.sv
// Disk head position tracking, block counting and ID capture with APB registers
//
// Register access over APB and the address map were chosen for this implementation.
module dpc_top (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [dpc_pkg::AW-1:0] i_paddr,
  input  wire logic [31:0]           i_pwdata,
  output logic      [31:0]           o_prdata,
  output logic                       o_pready,
  output logic                       o_pslverr,
  input  wire logic                  i_id_start,
  input  wire logic                  i_id_byte_vld,
  input  wire logic [7:0]            i_id_byte,
  input  wire logic                  i_id_end,
  input  wire logic                  i_id_crc_ok,
  input  wire logic                  i_data_end,
  input  wire logic                  i_ecc_end,
  input  wire logic                  i_ecc_err,
  input  wire logic                  i_block_good_indication,
  input  wire logic                  i_corr_done,
  input  wire logic                  i_uncorr,
  input  wire logic                  i_skip_blk,
  input  wire logic                  i_pipe_bound,
  input  wire logic                  i_host_blk_taken,
  output logic                       o_more_blocks,
  output logic                       o_seq_stop,
  output logic                       o_irq
);
  import dpc_pkg::*;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [31:0]       exp_id;
    logic [IDW-1:0]    id_sr;
    logic              match_pend;
    logic              capture_full_flag;
    logic              ecc_hold;
    logic              pend_upd;
    logic              pend_crossed;
    logic              pending_increment_flag;
    logic              seq_stop;
    logic [NIRQ-1:0]   irq_stat;
    logic [NIRQ-1:0]   irq_mask;
    logic [CW-1:0]     snap_ext;
    logic [CW-1:0]     snap_good;
    logic [CW-1:0]     pipe_int;
    logic [CW-1:0]     pipe_ext;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              more;
    logic              irq;
  } dpc_st_t;

  dpc_st_t s_r;
  dpc_st_t s_nxt;

  dpc_cnt_if int_cnt ();
  dpc_cnt_if ext_cnt ();
  dpc_cnt_if good_cnt ();
  dpc_id_if  act_a ();
  dpc_id_if  act_b ();
  dpc_id_if  cap ();

  dpc_cnt u_int_cnt (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .c     (int_cnt.cnt)
  );
  dpc_cnt u_ext_cnt (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .c     (ext_cnt.cnt)
  );
  dpc_cnt u_good_cnt (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .c     (good_cnt.cnt)
  );
  dpc_idset u_act_a (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .r        (act_a.reg_side)
  );
  dpc_idset u_act_b (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .r        (act_b.reg_side)
  );
  dpc_idset u_cap (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .r        (cap.reg_side)
  );

  logic            setup;
  logic            wr;
  logic            id_match;
  logic [31:0]     exp_inc;
  logic [31:0]     dstat;
  logic [NIRQ-1:0] irq_set;
  logic [NIRQ-1:0] irq_clr;
  logic            snap;
  logic            rearm;

  // Compare only the bytes that the selected ID format uses
  always_comb begin
    id_match = 1'b0;
    exp_inc  = s_r.exp_id;
    if (s_r.ctrl[CTRL_LBA] && !s_r.ctrl[CTRL_LBA4]) begin
      id_match = (s_r.id_sr[23:0] == s_r.exp_id[23:0]);
      exp_inc  = {8'h00, s_r.exp_id[23:0] + 24'h00_0001};
    end else if (s_r.ctrl[CTRL_LBA]) begin
      id_match = (s_r.id_sr[31:0] == s_r.exp_id);
      exp_inc  = s_r.exp_id + 32'h0000_0001;
    end else begin
      // Cylinder/head/sector: only the sector byte steps
      id_match = (s_r.id_sr[31:0] == s_r.exp_id);
      exp_inc  = {s_r.exp_id[31:8], s_r.exp_id[7:0] + 8'h01};
    end
  end

  assign dstat = {27'h0, s_r.pend_upd, s_r.seq_stop, s_r.pending_increment_flag,
                  s_r.capture_full_flag, s_r.ecc_hold};

  always_comb begin
    s_nxt           = s_r;
    setup           = i_psel && !i_penable;
    wr              = i_psel && i_penable && s_r.pready && i_pwrite;
    irq_set         = '0;
    irq_clr         = '0;
    snap            = 1'b0;
    rearm           = 1'b0;
    int_cnt.ld      = 1'b0;
    int_cnt.ld_val  = s_r.pipe_int;
    int_cnt.inc     = 1'b0;
    int_cnt.dec     = 1'b0;
    ext_cnt.ld      = 1'b0;
    ext_cnt.ld_val  = s_r.pipe_ext;
    ext_cnt.inc     = 1'b0;
    ext_cnt.dec     = 1'b0;
    good_cnt.ld     = 1'b0;
    good_cnt.ld_val = '0;
    good_cnt.inc    = 1'b0;
    // Host side draws good blocks back out of the buffer
    good_cnt.dec    = i_host_blk_taken;
    act_a.ld        = 1'b0;
    act_a.d         = s_r.id_sr;
    act_b.ld        = 1'b0;
    act_b.d         = s_r.id_sr;
    cap.ld          = 1'b0;
    cap.d           = s_r.id_sr;

    // APB: one wait-free access, read data latched in the setup cycle
    s_nxt.pready = setup;
    // Error flag stands only beside pready
    s_nxt.pslverr = 1'b0;
    if (setup) begin
      s_nxt.prdata  = 32'h0000_0000;
      s_nxt.pslverr = 1'b0;
      unique case (i_paddr)
        OFF_CTRL:      s_nxt.prdata = {28'h0, s_r.ctrl};
        OFF_EXP_ID:    s_nxt.prdata = s_r.exp_id;
        OFF_ACTA_LO:   s_nxt.prdata = act_a.q[31:0];
        OFF_ACTA_HI:   s_nxt.prdata = act_a.q[63:32];
        OFF_ACTB_LO:   s_nxt.prdata = act_b.q[31:0];
        OFF_ACTB_HI:   s_nxt.prdata = act_b.q[63:32];
        OFF_CAP_LO:    s_nxt.prdata = cap.q[31:0];
        OFF_CAP_HI:    s_nxt.prdata = cap.q[63:32];
        OFF_DSTAT:     s_nxt.prdata = dstat;
        OFF_INT_CNT:   s_nxt.prdata = {16'h0, int_cnt.q};
        OFF_EXT_CNT:   s_nxt.prdata = {16'h0, ext_cnt.q};
        OFF_GOOD_CNT:  s_nxt.prdata = {16'h0, good_cnt.q};
        OFF_SNAP_EXT:  s_nxt.prdata = {16'h0, s_r.snap_ext};
        OFF_SNAP_GOOD: s_nxt.prdata = {16'h0, s_r.snap_good};
        OFF_PIPE_CNT:  s_nxt.prdata = {s_r.pipe_ext, s_r.pipe_int};
        OFF_IRQ_STAT:  s_nxt.prdata = {29'h0, s_r.irq_stat};
        OFF_IRQ_MASK:  s_nxt.prdata = {29'h0, s_r.irq_mask};
        default:       s_nxt.pslverr = 1'b1;
      endcase
    end

    if (wr) begin
      unique case (i_paddr)
        OFF_CTRL: begin
          s_nxt.ctrl = i_pwdata[CTRL_W-1:0];
          if (i_pwdata[CTRL_REARM]) begin
            s_nxt.capture_full_flag = 1'b0;
          end
          rearm = i_pwdata[CTRL_REARM];
          if (i_pwdata[CTRL_RELEASE]) begin
            s_nxt.ecc_hold = 1'b0;
            s_nxt.seq_stop = 1'b0;
          end
          snap = i_pwdata[CTRL_SNAP];
        end
        OFF_EXP_ID: begin
          s_nxt.exp_id     = i_pwdata;
          // A new target drops a match still waiting for its data field
          s_nxt.match_pend = 1'b0;
        end
        OFF_INT_CNT: begin
          int_cnt.ld     = 1'b1;
          int_cnt.ld_val = i_pwdata[CW-1:0];
          ext_cnt.ld     = 1'b1;
          ext_cnt.ld_val = i_pwdata[CW-1:0];
        end
        OFF_GOOD_CNT: begin
          good_cnt.ld     = 1'b1;
          good_cnt.ld_val = i_pwdata[CW-1:0];
        end
        OFF_PIPE_CNT: begin
          s_nxt.pipe_int = i_pwdata[CW-1:0];
          s_nxt.pipe_ext = i_pwdata[31:16];
        end
        OFF_IRQ_STAT: irq_clr = i_pwdata[NIRQ-1:0];
        OFF_IRQ_MASK: s_nxt.irq_mask = i_pwdata[NIRQ-1:0];
        default: begin
        end
      endcase
    end

    // Snapshot of the live external and good counts for firmware
    if (snap) begin
      s_nxt.snap_ext  = ext_cnt.q;
      s_nxt.snap_good = good_cnt.q;
    end

    // ID field assembly, newest byte lowest
    if (i_id_start) begin
      s_nxt.id_sr      = '0;
      // A retried ID with no data field must not step the expected ID
      s_nxt.match_pend = 1'b0;
    end else if (i_id_byte_vld) begin
      s_nxt.id_sr = {s_r.id_sr[IDW-9:0], i_id_byte};
    end

    if (i_id_end && i_id_crc_ok) begin
      // Rearm in the same cycle frees the set, so this ID is kept
      if (!s_r.capture_full_flag || rearm) begin
        cap.ld                  = 1'b1;
        s_nxt.capture_full_flag = 1'b1;
        irq_set[IRQ_CAP]        = 1'b1;
      end
      // A full capture set keeps the first position until rearmed
      if (id_match) begin
        s_nxt.match_pend = 1'b1;
        if (s_r.ecc_hold) begin
          act_b.ld = 1'b1;
        end else begin
          act_a.ld = 1'b1;
        end
      end
    end

    if (i_data_end && s_r.match_pend) begin
      s_nxt.exp_id     = exp_inc;
      s_nxt.match_pend = 1'b0;
    end

    // Skipped blocks still advance position and external count
    if (i_skip_blk && s_r.ctrl[CTRL_SKIP]) begin
      int_cnt.dec  = 1'b1;
      ext_cnt.dec  = 1'b1;
      s_nxt.exp_id = exp_inc;
    end

    if (i_corr_done && s_r.pend_upd) begin
      good_cnt.inc                 = 1'b1;
      if (!s_r.pend_crossed) begin
        ext_cnt.dec = 1'b1;
      end
      s_nxt.pend_upd               = 1'b0;
      s_nxt.ecc_hold               = 1'b0;
      s_nxt.pending_increment_flag = 1'b0;
    end

    if (i_uncorr && s_r.pend_upd) begin
      s_nxt.pend_upd      = 1'b0;
      irq_set[IRQ_UNCORR] = 1'b1;
      // Flag stays set: the old pipeline's last sector never landed
      if (s_r.pend_crossed) begin
        s_nxt.seq_stop = 1'b1;
      end
    end

    // End of sector: internal count always steps
    // Placed after the correction results so a new error in the
    // same cycle is not wiped by the old sector's clear
    if (i_ecc_end) begin
      int_cnt.dec = 1'b1;
      if (s_r.ctrl[CTRL_WRITE]) begin
        ext_cnt.dec  = 1'b1;
        good_cnt.inc = 1'b1;
      end else if (i_ecc_err) begin
        s_nxt.pend_upd     = 1'b1;
        s_nxt.pend_crossed = 1'b0;
        s_nxt.ecc_hold     = 1'b1;
      end else if (i_block_good_indication) begin
        ext_cnt.dec  = 1'b1;
        good_cnt.inc = 1'b1;
      end
    end

    // Reload wins over the block step above, correction pending or not
    if (i_pipe_bound) begin
      int_cnt.ld     = 1'b1;
      int_cnt.ld_val = s_r.pipe_int;
      ext_cnt.ld     = 1'b1;
      ext_cnt.ld_val = s_r.pipe_ext;
      if (s_nxt.pend_upd) begin
        s_nxt.pend_crossed           = 1'b1;
        s_nxt.pending_increment_flag = 1'b1;
        irq_set[IRQ_PEND]            = 1'b1;
      end
    end

    // Set beats a same-cycle write-one clear
    s_nxt.irq_stat = (s_r.irq_stat & ~irq_clr) | irq_set;
    // Interrupt follows status and mask at the same edge
    s_nxt.irq      = |(s_nxt.irq_stat & s_nxt.irq_mask);
    s_nxt.more     = (int_cnt.q != '0);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_r          <= '0;
      s_r.ctrl     <= CTRL_RST;
      s_r.exp_id   <= EXP_RST;
      s_r.irq_mask <= MASK_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_prdata      = s_r.prdata;
  assign o_pready      = s_r.pready;
  assign o_pslverr     = s_r.pslverr;
  assign o_more_blocks = s_r.more;
  assign o_seq_stop    = s_r.seq_stop;
  assign o_irq         = s_r.irq;
endmodule

// >>> test/dpc_checker.sv
// Port-level assertions for the position and count capture block
module dpc_checker
  import dpc_pkg::*;
(
  input wire logic          i_clk,
  input wire logic          i_rst,
  input wire logic          i_psel,
  input wire logic          i_penable,
  input wire logic          i_pwrite,
  input wire logic [AW-1:0] i_paddr,
  input wire logic [31:0]   i_pwdata,
  input wire logic [31:0]   o_prdata,
  input wire logic          o_pready,
  input wire logic          o_pslverr,
  input wire logic          i_id_end,
  input wire logic          i_uncorr,
  input wire logic          i_pipe_bound,
  input wire logic          o_seq_stop,
  input wire logic          o_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic wr_acc;
  logic irq_cause;
  assign wr_acc    = i_psel && i_penable && i_pwrite && o_pready;
  // Only these can set a status or mask bit
  assign irq_cause = i_id_end || i_uncorr || i_pipe_bound || wr_acc;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  ready_after_setup_a: assert property (i_psel && !i_penable |=> o_pready)
    else $error("pready missing after setup");
  ready_single_a: assert property (o_pready |=> !o_pready)
    else $error("pready held two cycles");
  err_decode_a: assert property (i_psel && !i_penable |=>
    o_pslverr == (i_paddr > 8'h40 || i_paddr[1:0] != 2'h0))
    else $error("slave error does not match address decode");
  err_zero_a: assert property (o_pslverr && !i_pwrite |-> o_prdata == 32'h0)
    else $error("refused read returned data");
  rdata_hold_a: assert property (!(i_psel && !i_penable) |=> $stable(o_prdata))
    else $error("read data changed outside setup");
  irq_rise_a: assert property ($rose(o_irq) |-> $past(irq_cause))
    else $error("interrupt rose without a cause");
  irq_fall_a: assert property ($fell(o_irq) |-> $past(wr_acc))
    else $error("interrupt fell without a register write");
  stop_rise_a: assert property ($rose(o_seq_stop) |-> $past(i_uncorr))
    else $error("sequencer stop without uncorrectable result");
  stop_fall_a: assert property ($fell(o_seq_stop) |->
    $past(wr_acc && i_paddr == OFF_CTRL && i_pwdata[CTRL_RELEASE]))
    else $error("sequencer stop cleared without release");
endmodule

bind dpc_top dpc_checker u_chk (
  .i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
  .o_pready, .o_pslverr, .i_id_end, .i_uncorr, .i_pipe_bound, .o_seq_stop, .o_irq
);

// >>> test/dpc_top_tb.sv
// Self-checking bench for the position and count capture block
module dpc_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dpc_pkg::*;
  localparam int E_ST = 0, E_BY = 1, E_IE = 2, E_DE = 3, E_EC = 4;
  localparam int E_CO = 5, E_UN = 6, E_SK = 7, E_PB = 8, E_HT = 9;
  logic        i_clk = 1'b0, i_rst = 1'b1;
  logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic [7:0]  i_paddr = 8'h00, i_id_byte = 8'h00;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rv, v;
  logic [9:0]  ev = 10'h000;
  logic [1:0]  q = 2'h0;
  logic        o_pready, o_pslverr, o_more_blocks, o_seq_stop, o_irq, se;
  int          n_mismatch = 0, check_count = 0, cyc = 0, ic, xc, gc, k;

  // Qualifiers: q[1] ecc error, q[0] block good or id crc good
  dpc_top DUT (
    .i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
    .o_pready, .o_pslverr, .i_id_start(ev[E_ST]), .i_id_byte_vld(ev[E_BY]), .i_id_byte,
    .i_id_end(ev[E_IE]), .i_id_crc_ok(q[0]), .i_data_end(ev[E_DE]), .i_ecc_end(ev[E_EC]),
    .i_ecc_err(q[1]), .i_block_good_indication(q[0]), .i_corr_done(ev[E_CO]),
    .i_uncorr(ev[E_UN]), .i_skip_blk(ev[E_SK]), .i_pipe_bound(ev[E_PB]),
    .i_host_blk_taken(ev[E_HT]), .o_more_blocks, .o_seq_stop, .o_irq
  );

  always #12.5 i_clk = ~i_clk;

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    {i_psel, i_penable} <= 2'b00;
    rv = o_prdata;
    se = o_pslverr;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rv, e);
  endtask

  task automatic rb(input logic [7:0] a, input int b, input logic e);
    apb(1'b0, a, 32'h0);
    chk(32'(rv[b]), 32'(e));
  endtask

  task automatic pulse(input int b, input logic [1:0] qq = 2'h0, input logic [7:0] d = 8'h00);
    @(posedge i_clk);
    ev[b] <= 1'b1;
    q <= qq;
    i_id_byte <= d;
    @(posedge i_clk);
    ev <= 10'h000;
    repeat (2) @(posedge i_clk);
  endtask

  // Newest byte shifts in last, so the most significant byte goes first
  task automatic idsend(input logic [31:0] id, input int nb, input logic ok);
    pulse(E_ST);
    for (int i = nb - 1; i >= 0; i--) pulse(E_BY, 2'h0, id[8*i +: 8]);
    pulse(E_IE, {1'b0, ok});
  endtask

  task automatic good_blk();
    pulse(E_EC, 2'b01);
    ic--;
    xc--;
    gc++;
  endtask

  task automatic cnts();
    rc(OFF_INT_CNT, 32'(ic));
    rc(OFF_EXT_CNT, 32'(xc));
    rc(OFF_GOOD_CNT, 32'(gc));
    chk(32'(o_more_blocks), 32'(ic != 0));
  endtask

  // Head-sector form steps only the low byte, with no carry
  function automatic logic [31:0] nxt_chs(input logic [31:0] x);
    return {x[31:8], x[7:0] + 8'h01};
  endfunction

  initial begin
    void'($urandom(53142));
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    rc(OFF_DSTAT, 32'h0);
    rc(OFF_GOOD_CNT, 32'h0);
    for (k = 0; k < 4; k++) begin
      apb(k[0], (k == 3) ? 8'h06 : 8'($urandom_range(255, 68)), 32'hFFFF_FFFF);
      chk(32'(se), 32'h1);
      chk(k[0] ? 32'h0 : rv, 32'h0);
    end
    v = $urandom & 32'hFFFF_FF8F;
    wr(OFF_CTRL, v);
    rc(OFF_CTRL, v & 32'hF);
    $display("test registers done");
    v = $urandom_range(32'hFF_FFFE);
    wr(OFF_CTRL, 32'h1);
    wr(OFF_EXP_ID, v);
    wr(OFF_IRQ_MASK, 32'h7);
    idsend(v, 3, 1'b1);
    rc(OFF_CAP_LO, v);
    rc(OFF_ACTA_LO, v);
    rc(OFF_ACTA_HI, 32'h0);
    rc(OFF_DSTAT, 32'h2);
    rc(OFF_IRQ_STAT, 32'h1);
    chk(32'(o_irq), 32'h1);
    pulse(E_DE);
    rc(OFF_EXP_ID, v + 1);
    idsend(v + 1, 3, 1'b0);
    rc(OFF_ACTA_LO, v);
    idsend(v + 1, 3, 1'b1);
    rc(OFF_ACTA_LO, v + 1);
    rc(OFF_CAP_LO, v);
    wr(OFF_IRQ_STAT, 32'h1);
    wr(OFF_CTRL, 32'h13);
    rc(OFF_DSTAT, 32'h0);
    chk(32'(o_irq), 32'h0);
    wr(OFF_IRQ_MASK, 32'h6);
    v = $urandom;
    wr(OFF_EXP_ID, v);
    idsend(v, 4, 1'b1);
    rc(OFF_ACTA_LO, v);
    rc(OFF_CAP_LO, v);
    chk(32'(o_irq), 32'h0);
    wr(OFF_IRQ_MASK, 32'h7);
    repeat (2) @(posedge i_clk);
    chk(32'(o_irq), 32'h1);
    wr(OFF_IRQ_STAT, 32'h1);
    wr(OFF_CTRL, 32'h10);
    v[7:0] = 8'hFF;
    wr(OFF_EXP_ID, v);
    idsend(v, 4, 1'b1);
    pulse(E_DE);
    rc(OFF_EXP_ID, nxt_chs(v));
    $display("test id capture done");
    wr(OFF_CTRL, 32'h1);
    ic = $urandom_range(20, 10);
    xc = ic;
    gc = 0;
    wr(OFF_INT_CNT, 32'(ic));
    wr(OFF_GOOD_CNT, 32'h0);
    cnts();
    for (k = 0; k < 6; k++) begin
      v = $urandom_range(2);
      if (v == 0) begin
        good_blk();
      end else if (v == 1) begin
        pulse(E_EC, 2'b10);
        ic--;
        cnts();
        rb(OFF_DSTAT, DST_SEL_B, 1'b1);
        pulse(E_CO);
        xc--;
        gc++;
      end else if (gc > 0) begin
        pulse(E_HT);
        gc--;
      end
      cnts();
    end
    v = $urandom_range(32'hFF_FFF0);
    wr(OFF_EXP_ID, v);
    idsend(v, 3, 1'b1);
    pulse(E_DE);
    pulse(E_EC, 2'b10);
    ic--;
    idsend(v + 1, 3, 1'b1);
    rc(OFF_ACTA_LO, v);
    rc(OFF_ACTB_LO, v + 1);
    pulse(E_UN);
    cnts();
    rb(OFF_IRQ_STAT, IRQ_UNCORR, 1'b1);
    rb(OFF_DSTAT, DST_SEL_B, 1'b1);
    wr(OFF_CTRL, 32'h21);
    rb(OFF_DSTAT, DST_SEL_B, 1'b0);
    wr(OFF_CTRL, 32'h41);
    rc(OFF_SNAP_EXT, 32'(xc));
    rc(OFF_SNAP_GOOD, 32'(gc));
    wr(OFF_CTRL, 32'h5);
    pulse(E_SK);
    ic--;
    xc--;
    cnts();
    wr(OFF_CTRL, 32'h9);
    good_blk();
    pulse(E_EC, 2'b10);
    ic--;
    xc--;
    gc++;
    cnts();
    wr(OFF_CTRL, 32'h1);
    while (ic > 0) good_blk();
    cnts();
    $display("test counts done");
    wr(OFF_INT_CNT, 32'h2);
    for (k = 0; k < 2; k++) begin
      v = {16'($urandom_range(99, 5)), 16'($urandom_range(99, 5))};
      wr(OFF_PIPE_CNT, v);
      pulse(E_EC, 2'b10);
      pulse(E_PB);
      ic = int'(v[15:0]);
      xc = int'(v[31:16]);
      cnts();
      rb(OFF_DSTAT, DST_PEND, 1'b1);
      pulse(k ? E_UN : E_CO);
      gc += (k == 0);
      cnts();
      rb(OFF_DSTAT, DST_PEND, k[0]);
      chk(32'(o_seq_stop), 32'(k[0]));
    end
    pulse(E_EC, 2'b00);
    ic--;
    cnts();
    wr(OFF_CTRL, 32'h21);
    repeat (2) @(posedge i_clk);
    chk(32'(o_seq_stop), 32'h0);
    $display("test pipeline done");
    summarize();
  end
endmodule
